// [design/edmod_edge_if.sv]
// edge events passed from the input synchroniser to the timer core
`timescale 1ns/1ns
`default_nettype none
interface edmod_edge_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface
`default_nettype wire

// [design/edmod_edge_sync.sv]
// pulse input synchroniser and edge detector
`timescale 1ns/1ns
`default_nettype none
module edmod_edge_sync (
  input wire logic sys_clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic pulse_in, // external modulated input
  edmod_edge_if.src edge_o // one-cycle edge pulses
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } edmod_sync_t;
  edmod_sync_t st_reg;
  edmod_sync_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.meta = pulse_in;
    st_next.sync = st_reg.meta;
    st_next.last = st_reg.sync;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // compare two settled samples, never the first stage
  assign edge_o.rise = st_reg.sync & ~st_reg.last;
  assign edge_o.fall = ~st_reg.sync & st_reg.last;
endmodule
`default_nettype wire

// [design/edmod_irq.sv]
// sticky interrupt status with write-one clear and enable mask
`timescale 1ns/1ns
`default_nettype none
module edmod_irq #(
  parameter int unsigned N = 2
) (
  input wire logic sys_clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic [N-1:0] set, // event pulses
  input wire logic clr_wr, // clear register written
  input wire logic [N-1:0] clr_data, // ones clear bits
  input wire logic [N-1:0] enable, // per bit enable
  output logic [N-1:0] status, // sticky bits
  output logic irq // level interrupt
);
  typedef struct packed {
    logic [N-1:0] status;
  } edmod_irq_t;
  edmod_irq_t st_reg;
  edmod_irq_t st_next;
  logic [N-1:0] clr;

  always_comb begin
    st_next = st_reg;
    clr = clr_wr ? clr_data : '0;
    // set wins over a clear in the same cycle
    st_next.status = (st_reg.status & ~clr) | set;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign status = st_reg.status;
  assign irq = |(st_reg.status & enable);
endmodule
`default_nettype wire

// [design/edmod_pkg.sv]
// constants for the edge demodulation timer capture block
package edmod_pkg;
  localparam int unsigned AW = 14;
  localparam int unsigned DW = 8;
  // register indexes; byte address is four times the index
  localparam logic [11:0] IX_RELOAD_LOW = 12'hd00;
  localparam logic [11:0] IX_RELOAD_HIGH = 12'hd01;
  localparam logic [11:0] IX_TIMER_CTL = 12'hd02;
  localparam logic [11:0] IX_EDGE_CTL = 12'hd03;
  localparam logic [11:0] IX_EXTRA_CTL = 12'hd04;
  localparam logic [11:0] IX_RISE_CAP = 12'hd05;
  localparam logic [11:0] IX_FALL_CAP = 12'hd06;
  localparam logic [11:0] IX_WORD_HOLD = 12'hd07;
  localparam logic [11:0] IX_WORD_CAP = 12'hd08;
  localparam logic [11:0] IX_INT_STATUS = 12'hd09;
  localparam logic [11:0] IX_INT_CLEAR = 12'hd0a;
  localparam logic [11:0] IX_INT_ENABLE = 12'hd0b;
  localparam logic [11:0] IX_COUNT = 12'hd0c;
  localparam logic [13:0] A_RELOAD_LOW = {IX_RELOAD_LOW, 2'b00};
  localparam logic [13:0] A_RELOAD_HIGH = {IX_RELOAD_HIGH, 2'b00};
  localparam logic [13:0] A_TIMER_CTL = {IX_TIMER_CTL, 2'b00};
  localparam logic [13:0] A_EDGE_CTL = {IX_EDGE_CTL, 2'b00};
  localparam logic [13:0] A_EXTRA_CTL = {IX_EXTRA_CTL, 2'b00};
  localparam logic [13:0] A_RISE_CAP = {IX_RISE_CAP, 2'b00};
  localparam logic [13:0] A_FALL_CAP = {IX_FALL_CAP, 2'b00};
  localparam logic [13:0] A_WORD_HOLD = {IX_WORD_HOLD, 2'b00};
  localparam logic [13:0] A_WORD_CAP = {IX_WORD_CAP, 2'b00};
  localparam logic [13:0] A_INT_STATUS = {IX_INT_STATUS, 2'b00};
  localparam logic [13:0] A_INT_CLEAR = {IX_INT_CLEAR, 2'b00};
  localparam logic [13:0] A_INT_ENABLE = {IX_INT_ENABLE, 2'b00};
  localparam logic [13:0] A_COUNT = {IX_COUNT, 2'b00};
  // field positions
  localparam int unsigned B_TMR_EN = 0;
  localparam int unsigned B_TO_IE = 1;
  localparam int unsigned B_CAP_IE = 2;
  localparam int unsigned B_TO_FLAG = 5;
  localparam int unsigned B_SEL_LO = 4;
  localparam int unsigned B_RISE_FLAG = 0;
  localparam int unsigned B_FALL_FLAG = 1;
  localparam int unsigned B_DELAY = 4;
  localparam int unsigned B_INT_CAP = 0;
  localparam int unsigned B_INT_TO = 1;
  localparam int unsigned NUM_INT = 2;
  // edge select codes
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_RISE = 2'h1;
  localparam logic [1:0] SEL_FALL = 2'h2;
  localparam logic [1:0] SEL_BOTH = 2'h3;
  // reset and reload values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CNT_FULL = 8'hff;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [1:0] SKIP_EDGES = 2'h2;
  localparam logic [1:0] DELAY_CAPS = 2'h2;
  localparam int unsigned TICK_DIV = 1;
endpackage

// [design/edmod_top.sv]
// edge demodulation timer with capture bytes and word timer bytes
//
// What this block does
// - timer enabled, first selected edge starts the down count
// - later selected edge stores the complemented count
// - rising edge fills the rise capture byte, falling the fall byte
// - capture sets its edge flag; interrupt only if capture enable set
// - counter reloads with all ones on each capture
// - count reaching zero sets timeout flag; interrupt if enabled
// - after timeout counter wraps to all ones and keeps going
// - delayed start ignores two edges, third edge starts counting
// - delayed start captures edges four and five, interrupt after five
// - word capture low byte is read only, writes ignored
// - word hold high byte is read write and feeds the word timer
// - both word timer bytes clear to zero on full reset
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module edmod_top #(
  parameter int unsigned TICK_DIV = edmod_pkg::TICK_DIV
) (
  input wire logic sys_clk, // system clock, 125 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic [13:0] reg_addr, // register byte address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic pulse_in, // external modulated pulse
  input wire logic word_cap_stb, // word timer capture strobe
  input wire logic [7:0] word_cap_in, // word timer captured low byte
  output logic [7:0] word_hold_high, // upper load byte for word timer
  output logic irq // level interrupt
);
  ////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_SKIP = 3'b010,
    ST_RUN = 3'b100
  } edmod_state_t;

  typedef struct packed {
    edmod_state_t state;
    logic [1:0] edges;
    logic [7:0] cnt;
    logic [7:0] tick_cnt;
    logic [7:0] reload_low;
    logic [7:0] reload_high;
    logic tmr_en;
    logic to_ie;
    logic cap_ie;
    logic [1:0] edge_sel;
    logic [1:0] edge_flag;
    logic delay_en;
    logic [7:0] rise_cap;
    logic [7:0] fall_cap;
    logic [7:0] word_hold;
    logic [7:0] word_cap;
    logic [7:0] rdata;
  } edmod_top_t;

  edmod_top_t st_reg;
  edmod_top_t st_next;

  ////////////////////////////////////////////////////////////////////
  edmod_edge_if edge_bus ();

  edmod_edge_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pulse_in(pulse_in),
    .edge_o(edge_bus.src)
  );

  logic [edmod_pkg::NUM_INT-1:0] int_set;
  logic [edmod_pkg::NUM_INT-1:0] int_status;
  logic [edmod_pkg::NUM_INT-1:0] int_en_reg;
  logic [edmod_pkg::NUM_INT-1:0] int_en_next;
  logic [edmod_pkg::NUM_INT-1:0] int_gate;
  logic int_clr_wr;

  edmod_irq #(
    .N(edmod_pkg::NUM_INT)
  ) u_irq (
    .sys_clk(sys_clk),
    .rst(rst),
    .set(int_set),
    .clr_wr(int_clr_wr),
    .clr_data(reg_wdata[edmod_pkg::NUM_INT-1:0]),
    .enable(int_gate),
    .status(int_status),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////
  // qualified edge and tick
  logic sel_rise;
  logic sel_fall;
  logic qual;
  logic tick;
  logic wr_hit;

  assign sel_rise = edge_bus.rise & st_reg.edge_sel[0];
  assign sel_fall = edge_bus.fall & st_reg.edge_sel[1];
  assign qual = sel_rise | sel_fall;
  assign tick = (st_reg.tick_cnt == 8'(TICK_DIV - 1));
  assign wr_hit = reg_wr;

  // both the control bit and the mask must allow the line
  assign int_gate[edmod_pkg::B_INT_CAP] =
    st_reg.cap_ie & int_en_reg[edmod_pkg::B_INT_CAP];
  assign int_gate[edmod_pkg::B_INT_TO] =
    st_reg.to_ie & int_en_reg[edmod_pkg::B_INT_TO];
  assign int_clr_wr = wr_hit & (reg_addr == edmod_pkg::A_INT_CLEAR);

  ////////////////////////////////////////////////////////////////////
  localparam logic [1:0] DELAY_LAST = edmod_pkg::DELAY_CAPS - 2'h1;

  logic cap_ev;
  logic cap_irq_ev;
  logic to_ev;
  logic [7:0] cnt_dec;
  logic [1:0] flag_clr;

  always_comb begin
    st_next = st_reg;
    cap_ev = 1'b0;
    cap_irq_ev = 1'b0;
    to_ev = 1'b0;
    int_en_next = int_en_reg;
    cnt_dec = st_reg.cnt - 8'h01;
    flag_clr = 2'h0;

    // timer clock prescale
    if (tick) begin
      st_next.tick_cnt = 8'h00;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 8'h01;
    end

    case (st_reg.state)
      ST_WAIT: begin
        if (st_reg.tmr_en && qual) begin
          st_next.edges = 2'h0;
          if (st_reg.delay_en) begin
            // this edge is the first of the two ignored
            st_next.edges = 2'h1;
            st_next.state = ST_SKIP;
          end else begin
            st_next.cnt = edmod_pkg::CNT_FULL;
            st_next.state = ST_RUN;
          end
        end
      end
      ST_SKIP: begin
        if (qual) begin
          if (st_reg.edges == edmod_pkg::SKIP_EDGES) begin
            // third edge starts the count
            st_next.cnt = edmod_pkg::CNT_FULL;
            st_next.edges = 2'h0;
            st_next.state = ST_RUN;
          end else begin
            st_next.edges = st_reg.edges + 2'h1;
          end
        end
      end
      ST_RUN: begin
        if (qual) begin
          cap_ev = 1'b1;
          st_next.cnt = edmod_pkg::CNT_FULL;
          if (sel_rise) begin
            st_next.rise_cap = ~st_reg.cnt;
          end else begin
            st_next.fall_cap = ~st_reg.cnt;
          end
          if (st_reg.delay_en) begin
            st_next.edges = st_reg.edges + 2'h1;
            if (st_reg.edges == DELAY_LAST) begin
              // fifth edge: raise the interrupt, rearm for a new burst
              cap_irq_ev = 1'b1;
              st_next.edges = 2'h0;
              st_next.state = ST_WAIT;
            end
          end else begin
            cap_irq_ev = 1'b1;
          end
        end else if (tick) begin
          st_next.cnt = cnt_dec;
          if (cnt_dec == edmod_pkg::CNT_ZERO) begin
            to_ev = 1'b1;
          end
        end
      end
      default: begin
        st_next.state = ST_WAIT;
      end
    endcase

    // leaving enable drops any sequence in progress
    if (!st_reg.tmr_en) begin
      st_next.state = ST_WAIT;
      st_next.edges = 2'h0;
    end

    // register writes
    if (wr_hit) begin
      case (reg_addr)
        edmod_pkg::A_RELOAD_LOW: st_next.reload_low = reg_wdata;
        edmod_pkg::A_RELOAD_HIGH: st_next.reload_high = reg_wdata;
        edmod_pkg::A_TIMER_CTL: begin
          st_next.tmr_en = reg_wdata[edmod_pkg::B_TMR_EN];
          st_next.to_ie = reg_wdata[edmod_pkg::B_TO_IE];
          st_next.cap_ie = reg_wdata[edmod_pkg::B_CAP_IE];
        end
        edmod_pkg::A_EDGE_CTL: begin
          st_next.edge_sel = reg_wdata[edmod_pkg::B_SEL_LO +: 2];
          flag_clr = reg_wdata[1:0];
        end
        edmod_pkg::A_EXTRA_CTL: st_next.delay_en = reg_wdata[edmod_pkg::B_DELAY];
        edmod_pkg::A_WORD_HOLD: st_next.word_hold = reg_wdata;
        edmod_pkg::A_INT_ENABLE: int_en_next = reg_wdata[edmod_pkg::NUM_INT-1:0];
        // capture bytes and word capture are read only
        default: begin
        end
      endcase
    end

    // edge flags are sticky; a new capture beats a clear
    st_next.edge_flag = st_reg.edge_flag & ~flag_clr;
    if (cap_ev && sel_rise) begin
      st_next.edge_flag[edmod_pkg::B_RISE_FLAG] = 1'b1;
    end
    if (cap_ev && !sel_rise) begin
      st_next.edge_flag[edmod_pkg::B_FALL_FLAG] = 1'b1;
    end

    // word capture fed by the word timer only
    if (word_cap_stb) begin
      st_next.word_cap = word_cap_in;
    end

    // read data, one cycle after the strobe
    st_next.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        edmod_pkg::A_RELOAD_LOW: st_next.rdata = st_reg.reload_low;
        edmod_pkg::A_RELOAD_HIGH: st_next.rdata = st_reg.reload_high;
        edmod_pkg::A_TIMER_CTL: begin
          st_next.rdata[edmod_pkg::B_TMR_EN] = st_reg.tmr_en;
          st_next.rdata[edmod_pkg::B_TO_IE] = st_reg.to_ie;
          st_next.rdata[edmod_pkg::B_CAP_IE] = st_reg.cap_ie;
          st_next.rdata[edmod_pkg::B_TO_FLAG] = int_status[edmod_pkg::B_INT_TO];
        end
        edmod_pkg::A_EDGE_CTL: begin
          st_next.rdata[edmod_pkg::B_SEL_LO +: 2] = st_reg.edge_sel;
          st_next.rdata[1:0] = st_reg.edge_flag;
        end
        edmod_pkg::A_EXTRA_CTL: st_next.rdata[edmod_pkg::B_DELAY] = st_reg.delay_en;
        edmod_pkg::A_RISE_CAP: st_next.rdata = st_reg.rise_cap;
        edmod_pkg::A_FALL_CAP: st_next.rdata = st_reg.fall_cap;
        edmod_pkg::A_WORD_HOLD: st_next.rdata = st_reg.word_hold;
        edmod_pkg::A_WORD_CAP: st_next.rdata = st_reg.word_cap;
        edmod_pkg::A_INT_STATUS: st_next.rdata[edmod_pkg::NUM_INT-1:0] = int_status;
        edmod_pkg::A_INT_ENABLE: st_next.rdata[edmod_pkg::NUM_INT-1:0] = int_en_reg;
        edmod_pkg::A_COUNT: st_next.rdata = st_reg.cnt;
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  assign int_set[edmod_pkg::B_INT_CAP] = cap_irq_ev;
  assign int_set[edmod_pkg::B_INT_TO] = to_ev;

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg.state <= ST_WAIT;
      st_reg.edges <= 2'h0;
      st_reg.cnt <= edmod_pkg::CNT_FULL;
      st_reg.tick_cnt <= 8'h00;
      st_reg.reload_low <= edmod_pkg::RST_BYTE;
      st_reg.reload_high <= edmod_pkg::RST_BYTE;
      st_reg.tmr_en <= 1'b0;
      st_reg.to_ie <= 1'b0;
      st_reg.cap_ie <= 1'b0;
      st_reg.edge_sel <= edmod_pkg::SEL_NONE;
      st_reg.edge_flag <= 2'h0;
      st_reg.delay_en <= 1'b0;
      st_reg.rise_cap <= edmod_pkg::RST_BYTE;
      st_reg.fall_cap <= edmod_pkg::RST_BYTE;
      st_reg.word_hold <= edmod_pkg::RST_BYTE;
      st_reg.word_cap <= edmod_pkg::RST_BYTE;
      st_reg.rdata <= 8'h00;
      int_en_reg <= '0;
    end else begin
      st_reg <= st_next;
      int_en_reg <= int_en_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign word_hold_high = st_reg.word_hold;
endmodule
`default_nettype wire

// [tb/edmod_asserts.sv]
// port checker for the edge demodulation timer top
`timescale 1ns/1ns
`default_nettype none
module edmod_asserts (
  input wire logic sys_clk, // clock
  input wire logic rst, // reset
  input wire logic [13:0] reg_addr, // address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic pulse_in, // pulse line
  input wire logic word_cap_stb, // capture strobe
  input wire logic [7:0] word_cap_in, // captured byte
  input wire logic [7:0] word_hold_high, // hold byte
  input wire logic irq // interrupt
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [1:0] en_reg; // shadow of interrupt enable
  logic [1:0] ie_reg; // shadow of control enables b2:b1
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      en_reg <= 2'h0;
      ie_reg <= 2'h0;
    end else if (reg_wr && reg_addr == edmod_pkg::A_INT_ENABLE) begin
      en_reg <= reg_wdata[1:0];
    end else if (reg_wr && reg_addr == edmod_pkg::A_TIMER_CTL) begin
      ie_reg <= reg_wdata[2:1];
    end
  end
  ////////////////////////////////////////
  sequence s_cap_rd;
    word_cap_stb ##1 !word_cap_stb ##1 (reg_rd && reg_addr == edmod_pkg::A_WORD_CAP);
  endsequence
  sequence s_two_rd;
    (reg_rd && !word_cap_stb && reg_addr == edmod_pkg::A_WORD_CAP) [*2];
  endsequence
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_hold_wr;
    reg_wr && reg_addr == edmod_pkg::A_WORD_HOLD |=> word_hold_high == $past(reg_wdata);
  endproperty
  a_hold_wr: assert property (p_hold_wr) else $error("hold byte not written");
  property p_hold_keep;
    !(reg_wr && reg_addr == edmod_pkg::A_WORD_HOLD) |=> $stable(word_hold_high);
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("hold byte changed");
  property p_hold_rd;
    reg_rd && reg_addr == edmod_pkg::A_WORD_HOLD |=> reg_rdata == $past(word_hold_high);
  endproperty
  a_hold_rd: assert property (p_hold_rd) else $error("hold byte read wrong");
  property p_cap_rd;
    s_cap_rd |=> reg_rdata == $past(word_cap_in, 3);
  endproperty
  a_cap_rd: assert property (p_cap_rd) else $error("capture byte read wrong");
  property p_cap_keep;
    s_two_rd |=> reg_rdata == $past(reg_rdata);
  endproperty
  a_cap_keep: assert property (p_cap_keep) else $error("capture byte moved");
  property p_rst_out;
    $fell(rst) |-> word_hold_high == 8'h00 && !irq;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not clear");
  property p_irq_gate;
    irq |-> (ie_reg[1] && en_reg[0]) || (ie_reg[0] && en_reg[1]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not enabled");
  property p_mask_off;
    reg_wr && reg_addr == edmod_pkg::A_INT_ENABLE && reg_wdata[1:0] == 2'h0 |=> !irq [*3];
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq while masked");
endmodule
bind edmod_top edmod_asserts edmod_asserts_inst (.sys_clk, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .pulse_in, .word_cap_stb, .word_cap_in,
  .word_hold_high, .irq);
`default_nettype wire

// [tb/edmod_pulse_model.sv]
// pulse source model driving the modulated input line
`timescale 1ns/1ns
`default_nettype none
module edmod_pulse_model (
  input wire logic sys_clk, // system clock
  output logic pulse_in // modulated pulse line
);
  // the line is always driven, so it never floats between edges
  initial pulse_in = 1'b0;
  task automatic step(input int gap);
    repeat (gap) @(posedge sys_clk);
    pulse_in <= ~pulse_in;
  endtask
endmodule
`default_nettype wire

// [tb/edmod_tb_top.sv]
// self-checking bench for the edge demodulation timer
`timescale 1ns/1ns
`default_nettype none
module edmod_tb_top;
  logic sys_clk;
  logic rst;
  logic [13:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic pulse_in;
  logic word_cap_stb;
  logic [7:0] word_cap_in;
  logic [7:0] word_hold_high;
  logic irq;
  logic [7:0] v;
  logic [7:0] w;
  int n_errors = 0;
  int comparisons = 0;
  edmod_top #(.TICK_DIV(1)) edmod_top_inst (.sys_clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .pulse_in, .word_cap_stb, .word_cap_in,
    .word_hold_high, .irq);
  edmod_pulse_model edmod_pulse_model_inst (.sys_clk, .pulse_in);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data is taken at the edge closing its cycle, before it clears
  task automatic rd(input logic [13:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask
  task automatic rc(input logic [13:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  // stop, clear flags, select edges, enable, then toggle the line
  task automatic run(input logic [7:0] ctl, input logic [1:0] sel, input int g0, input int g1,
                     input int g2);
    wr(edmod_pkg::A_TIMER_CTL, 8'h00);
    wr(edmod_pkg::A_EDGE_CTL, {2'h0, sel, 4'h3});
    wr(edmod_pkg::A_INT_CLEAR, 8'h03);
    wr(edmod_pkg::A_TIMER_CTL, ctl);
    edmod_pulse_model_inst.step(g0);
    edmod_pulse_model_inst.step(g1);
    edmod_pulse_model_inst.step(g2);
    repeat (6) @(posedge sys_clk);
  endtask
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    reg_addr = 14'h0000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    word_cap_stb = 1'b0;
    word_cap_in = 8'h00;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rc(edmod_pkg::A_WORD_HOLD, 8'h00);
    rc(edmod_pkg::A_WORD_CAP, 8'h00);
    rc(14'h3ffc, 8'h00);
    wr(edmod_pkg::A_WORD_HOLD, 8'ha5);
    rc(edmod_pkg::A_WORD_HOLD, 8'ha5);
    chk(word_hold_high, 8'ha5);
    @(posedge sys_clk);
    word_cap_stb <= 1'b1;
    word_cap_in <= 8'h3c;
    @(posedge sys_clk);
    word_cap_stb <= 1'b0;
    rc(edmod_pkg::A_WORD_CAP, 8'h3c);
    wr(edmod_pkg::A_WORD_CAP, 8'h55);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= edmod_pkg::A_WORD_CAP;
    repeat (2) @(posedge sys_clk);
    reg_rd <= 1'b0;
    chk(reg_rdata, 8'h3c);
    @(posedge sys_clk);
    chk(reg_rdata, 8'h3c);
    // full reset in mid-run must clear both word timer bytes
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rc(edmod_pkg::A_WORD_HOLD, 8'h00);
    rc(edmod_pkg::A_WORD_CAP, 8'h00);
    chk(word_hold_high, 8'h00);
    wr(edmod_pkg::A_RELOAD_LOW, 8'hff);
    wr(edmod_pkg::A_RELOAD_HIGH, 8'hff);
    wr(edmod_pkg::A_INT_ENABLE, 8'h03);
    // both edges: rise starts, fall after 20, rise after 30
    run(8'h05, edmod_pkg::SEL_BOTH, 2, 20, 30);
    rc(edmod_pkg::A_FALL_CAP, 8'h13);
    rc(edmod_pkg::A_RISE_CAP, 8'h1d);
    rc(edmod_pkg::A_EDGE_CTL, 8'h33);
    chk({7'h00, irq}, 8'h01);
    wr(edmod_pkg::A_INT_CLEAR, 8'h01);
    @(posedge sys_clk);
    chk({7'h00, irq}, 8'h00);
    // falling only, interrupt masked: the rise in between is ignored
    wr(edmod_pkg::A_INT_ENABLE, 8'h00);
    run(8'h05, edmod_pkg::SEL_FALL, 2, 10, 15);
    rc(edmod_pkg::A_FALL_CAP, 8'h18);
    rc(edmod_pkg::A_RISE_CAP, 8'h1d);
    rc(edmod_pkg::A_INT_STATUS, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr(edmod_pkg::A_INT_ENABLE, 8'h03);
    run(8'h05, edmod_pkg::SEL_RISE, 2, 10, 18);
    rc(edmod_pkg::A_RISE_CAP, 8'h1b);
    rc(edmod_pkg::A_FALL_CAP, 8'h18);
    run(8'h05, edmod_pkg::SEL_NONE, 2, 10, 10);
    rc(edmod_pkg::A_EDGE_CTL, 8'h00);
    // delayed start: third edge starts, fourth and fifth capture
    wr(edmod_pkg::A_EXTRA_CTL, 8'h10);
    run(8'h05, edmod_pkg::SEL_BOTH, 2, 10, 10);
    edmod_pulse_model_inst.step(6);
    repeat (6) @(posedge sys_clk);
    chk({7'h00, irq}, 8'h00);
    edmod_pulse_model_inst.step(8);
    repeat (6) @(posedge sys_clk);
    chk({7'h00, irq}, 8'h01);
    rc(edmod_pkg::A_FALL_CAP, 8'h0b);
    rc(edmod_pkg::A_RISE_CAP, 8'h0d);
    // time-out: let the count run past zero, it must keep going
    wr(edmod_pkg::A_EXTRA_CTL, 8'h00);
    wr(edmod_pkg::A_INT_ENABLE, 8'h02);
    run(8'h03, edmod_pkg::SEL_BOTH, 2, 2, 2);
    repeat (270) @(posedge sys_clk);
    chk({7'h00, irq}, 8'h01);
    rc(edmod_pkg::A_TIMER_CTL, 8'h23);
    rd(edmod_pkg::A_COUNT, v);
    rd(edmod_pkg::A_COUNT, w);
    chk(v - w, 8'h03);
    print_verdict();
  end
endmodule
`default_nettype wire
